// [hpr_pkg.sv]
/*
 * Shared constants of the host port: bus widths, fixed address of the
 * interrupt FIFO register, reset values, default counts and sequencer states.
 * Assumes nothing of its surroundings; included first in compile order.
 */
package hpr_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;

	// ****************************************************************
	// Addresses and reset values
	// ****************************************************************
	localparam logic [ADDR_W-1:0] IRQ_FIFO_ADDR = 11'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
	localparam logic [DATA_W-1:0] EMPTY_READ_VALUE = 8'h00;

	// ****************************************************************
	// Counts
	// ****************************************************************
	localparam int REG_COUNT_DEF = 2048;
	localparam int IRQ_DEPTH_DEF = 32;

	// ****************************************************************
	// Port sequencer states
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_STANDBY = 3'b000,
		ST_INIT = 3'b001,
		ST_IDLE = 3'b010,
		ST_FETCH = 3'b011,
		ST_LATCH = 3'b100,
		ST_ACK = 3'b101
	} hpr_state_e;

endpackage : hpr_pkg

// [hpr_fifo_if.sv]
/*
 * Carrier between the port sequencer and the interrupt entry store.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface hpr_fifo_if #(parameter int WIDTH = 8);
	logic push;
	logic [WIDTH-1:0] push_data;
	logic flush;
	logic fetch;
	logic pop;
	logic [WIDTH-1:0] fetch_data;
	logic empty;
	logic full;

	modport store (
		input push,
		input push_data,
		input flush,
		input fetch,
		input pop,
		output fetch_data,
		output empty,
		output full
	);

	modport ctrl (
		output push,
		output push_data,
		output flush,
		output fetch,
		output pop,
		input fetch_data,
		input empty,
		input full
	);
endinterface : hpr_fifo_if

`default_nettype wire

// [hpr_irq_fifo.sv]
/*
 * Interrupt entry store: a small circular memory with registered read data.
 * Assumes push, fetch, pop and flush are single-clock controls from mclk logic.
 */
`timescale 1ns/1ps
`default_nettype none

module hpr_irq_fifo #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	hpr_fifo_if.store port
);

	localparam int AW = $clog2(DEPTH);

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_depth
		$error("hpr_irq_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic [WIDTH-1:0] fetch_data_reg;
	wire do_push;
	wire do_pop;

	// A full store drops new entries rather than overwrite unread ones
	assign do_push = port.push & ~port.full;
	assign do_pop = port.pop & ~port.empty;
	assign port.empty = (count_reg == '0);
	assign port.full = (count_reg == (AW+1)'(DEPTH));
	assign port.fetch_data = fetch_data_reg;

	// Storage array, no reset needed
	always_ff @(posedge mclk)
	begin
		if (do_push)
			mem[wr_ptr_reg] <= port.push_data;
	end

	// Pointers; push and pop in one cycle leave the count alone
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else if (port.flush)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + AW'(do_push);
			rd_ptr_reg <= rd_ptr_reg + AW'(do_pop);
			count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	// Registered head read
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			fetch_data_reg <= '0;
		else if (port.fetch)
			fetch_data_reg <= mem[rd_ptr_reg];
	end

endmodule : hpr_irq_fifo

`default_nettype wire

// [hpr_host_port.sv]
/*
 * Asynchronous 8-bit host port with device reset, register initialisation
 * and open-drain interrupt request.
 * Assumes all pin inputs are asynchronous to mclk; the register datapath
 * beyond the port answers reg_rd with reg_rdata one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Reset pin low holds device in standby
// - After reset, load every register default
// - Any channel interrupt pulls request low (the code ignores irq_event while in standby)
// - Request released once interrupt FIFO empty
// - Select high: ignore strobe and bus
// - Read drives bus, write captures bus
// - Acknowledge low marks transfer complete
// - Bus driven only during read access
module hpr_host_port #(
	parameter int REG_COUNT = hpr_pkg::REG_COUNT_DEF,
	parameter int IRQ_DEPTH = hpr_pkg::IRQ_DEPTH_DEF,
	parameter logic [7:0] REG_DEFAULT = 8'h00
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic device_reset_n,
	input wire logic chip_select_n,
	input wire logic data_strobe_n,
	input wire logic read_not_write,
	input wire logic [10:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic transfer_ack_n_out,
	output logic transfer_ack_n_oe,
	output logic interrupt_request_n_out,
	output logic interrupt_request_n_oe,
	input wire logic irq_event,
	input wire logic [7:0] irq_code,
	output logic irq_dropped,
	output logic standby,
	output logic init_active,
	output logic [10:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);

	localparam int SYNC_W = 4 + hpr_pkg::ADDR_W + hpr_pkg::DATA_W;
	localparam int CNT_W = $clog2(REG_COUNT);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (REG_COUNT < 2 || REG_COUNT > (1 << hpr_pkg::ADDR_W))
	begin : g_bad_count
		$error("hpr_host_port: REG_COUNT must lie in 2..2048");
	end

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [SYNC_W-1:0] meta_reg;
	logic [SYNC_W-1:0] sync_reg;
	wire [SYNC_W-1:0] pins_raw;

	assign pins_raw = {device_reset_n, chip_select_n, data_strobe_n, read_not_write,
		addr, data_in};

	// Two stages; only the second stage feeds logic
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= {4'h6, 11'h000, 8'h00};
			sync_reg <= {4'h6, 11'h000, 8'h00};
		end
		else
		begin
			meta_reg <= pins_raw;
			sync_reg <= meta_reg;
		end
	end

	wire dev_rst_s_n;
	wire cs_s_n;
	wire ds_s_n;
	wire rnw_s;
	wire [10:0] addr_s;
	wire [7:0] din_s;
	wire access;

	assign {dev_rst_s_n, cs_s_n, ds_s_n, rnw_s, addr_s, din_s} = sync_reg;
	// Strobe counts only with select low; either alone does nothing
	assign access = ~cs_s_n & ~ds_s_n;

	// ****************************************************************
	// Interrupt entry store
	// ****************************************************************
	hpr_fifo_if #(.WIDTH(hpr_pkg::DATA_W)) fifo_bus ();

	hpr_irq_fifo #(
		.DEPTH(IRQ_DEPTH),
		.WIDTH(hpr_pkg::DATA_W)
	) u_irq_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.port(fifo_bus.store)
	);

	// ****************************************************************
	// Port sequencer
	// ****************************************************************
	hpr_pkg::hpr_state_e state_reg;
	hpr_pkg::hpr_state_e state_next;
	logic [CNT_W-1:0] init_cnt_reg;
	logic rnw_reg;
	logic is_fifo_reg;
	logic fifo_empty_reg;
	logic [7:0] data_out_reg;
	logic [10:0] reg_addr_reg;
	logic [7:0] reg_wdata_reg;
	logic reg_wr_reg;
	logic reg_rd_reg;

	wire init_last;
	wire hit_fifo;
	wire in_standby;

	assign init_last = (init_cnt_reg == CNT_W'(REG_COUNT - 1));
	assign hit_fifo = (addr_s == hpr_pkg::IRQ_FIFO_ADDR);
	assign in_standby = (state_reg == hpr_pkg::ST_STANDBY);

	// Next state; reset pin low overrides everything
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			hpr_pkg::ST_STANDBY: state_next = hpr_pkg::ST_INIT;
			hpr_pkg::ST_INIT: if (init_last) state_next = hpr_pkg::ST_IDLE;
			hpr_pkg::ST_IDLE:
			begin
				if (access)
					state_next = rnw_s ? hpr_pkg::ST_FETCH : hpr_pkg::ST_ACK;
			end
			hpr_pkg::ST_FETCH: state_next = hpr_pkg::ST_LATCH;
			hpr_pkg::ST_LATCH: state_next = hpr_pkg::ST_ACK;
			hpr_pkg::ST_ACK: if (!access) state_next = hpr_pkg::ST_IDLE;
			default: state_next = hpr_pkg::ST_STANDBY;
		endcase
		if (!dev_rst_s_n)
			state_next = hpr_pkg::ST_STANDBY;
	end

	// State and init address counter
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= hpr_pkg::ST_STANDBY;
			init_cnt_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			init_cnt_reg <= (state_reg == hpr_pkg::ST_INIT) ? init_cnt_reg + 1'b1 : '0;
		end
	end

	// Access capture at the start of a cycle
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rnw_reg <= 1'b0;
			is_fifo_reg <= 1'b0;
		end
		else if (state_reg == hpr_pkg::ST_IDLE && access)
		begin
			rnw_reg <= rnw_s;
			is_fifo_reg <= hit_fifo & rnw_s;
		end
	end

	// Register-side strobes; init walks addresses 0 to REG_COUNT-1 writing defaults
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_addr_reg <= hpr_pkg::ADDR_RST;
			reg_wdata_reg <= hpr_pkg::DATA_RST;
			reg_wr_reg <= 1'b0;
			reg_rd_reg <= 1'b0;
		end
		else if (state_next == hpr_pkg::ST_INIT)
		begin
			reg_addr_reg <= (state_reg == hpr_pkg::ST_INIT) ? 11'(init_cnt_reg + 1'b1) : '0;
			reg_wdata_reg <= REG_DEFAULT;
			reg_wr_reg <= 1'b1;
			reg_rd_reg <= 1'b0;
		end
		else
		begin
			reg_wr_reg <= 1'b0;
			reg_rd_reg <= 1'b0;
			if (state_reg == hpr_pkg::ST_IDLE && access && dev_rst_s_n)
			begin
				reg_addr_reg <= addr_s;
				reg_wdata_reg <= din_s;
				reg_wr_reg <= ~rnw_s;
				reg_rd_reg <= rnw_s & ~hit_fifo;
			end
		end
	end

	// Read data latch; an empty FIFO reads as a fixed value
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fifo_empty_reg <= 1'b1;
			data_out_reg <= hpr_pkg::DATA_RST;
		end
		else
		begin
			if (state_reg == hpr_pkg::ST_FETCH)
				fifo_empty_reg <= fifo_bus.empty;
			if (state_reg == hpr_pkg::ST_LATCH)
			begin
				if (!is_fifo_reg)
					data_out_reg <= reg_rdata;
				else if (fifo_empty_reg)
					data_out_reg <= hpr_pkg::EMPTY_READ_VALUE;
				else
					data_out_reg <= fifo_bus.fetch_data;
			end
		end
	end

	// ****************************************************************
	// Interrupt store control
	// ****************************************************************
	// Pop only as the read cycle closes, once the strobe is released in ACK
	assign fifo_bus.push = irq_event & ~in_standby;
	assign fifo_bus.push_data = irq_code;
	assign fifo_bus.flush = in_standby;
	assign fifo_bus.fetch = (state_reg == hpr_pkg::ST_FETCH) & is_fifo_reg;
	assign fifo_bus.pop = (state_reg == hpr_pkg::ST_ACK) & ~access & is_fifo_reg
		& ~fifo_empty_reg;
	assign irq_dropped = irq_event & ~in_standby & fifo_bus.full;

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	// Open-drain pins only ever drive low; enable high pulls the wire down
	assign transfer_ack_n_out = 1'b0;
	assign transfer_ack_n_oe = (state_reg == hpr_pkg::ST_ACK);
	assign interrupt_request_n_out = 1'b0;
	assign interrupt_request_n_oe = ~fifo_bus.empty;
	assign data_out = data_out_reg;
	assign data_oe = (state_reg == hpr_pkg::ST_ACK) & rnw_reg;
	assign standby = in_standby;
	assign init_active = (state_reg == hpr_pkg::ST_INIT);
	assign reg_addr = reg_addr_reg;
	assign reg_wdata = reg_wdata_reg;
	assign reg_wr = reg_wr_reg;
	assign reg_rd = reg_rd_reg;

endmodule : hpr_host_port

`default_nettype wire

// [hpr_host_port_asserts.sv]
/*
 * Checker for the host port: standby, init walk, ack timing, bus drive and interrupt line.
 * Assumes it is bound into every hpr_host_port and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none

module hpr_host_port_asserts #(
	parameter int REG_COUNT = 4,
	parameter logic [7:0] REG_DEFAULT = 8'h00
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic device_reset_n,
	input wire logic chip_select_n,
	input wire logic data_strobe_n,
	input wire logic read_not_write,
	input wire logic [10:0] addr,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic transfer_ack_n_out,
	input wire logic transfer_ack_n_oe,
	input wire logic interrupt_request_n_out,
	input wire logic interrupt_request_n_oe,
	input wire logic irq_event,
	input wire logic [7:0] irq_code,
	input wire logic irq_dropped,
	input wire logic standby,
	input wire logic init_active,
	input wire logic [10:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	// ****************
	// Helpers and properties
	// ****************
	int init_cnt;

	// Length of the current init walk; pins sync lag makes a plain delay unreliable
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			init_cnt <= 0;
		else
			init_cnt <= init_active ? init_cnt + 1 : 0;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Two sync stages, the state edge and the flush edge pass before the pins settle
	sequence s_pin_reset;
		!device_reset_n [*5];
	endsequence
	sequence s_released;
		data_strobe_n [*5];
	endsequence
	sequence s_read_answer;
		##2 ($rose(transfer_ack_n_oe) && data_oe && data_out == $past(reg_rdata));
	endsequence

	a_standby_on_reset: assert property (s_pin_reset |-> standby && !transfer_ack_n_oe
		&& !data_oe && !interrupt_request_n_oe) else $error("standby not held");
	a_init_first: assert property ($rose(init_active) |-> reg_wr
		&& reg_addr == 11'h000 && reg_wdata == REG_DEFAULT) else $error("init start wrong");
	a_init_length: assert property ($fell(init_active) && !standby
		|-> init_cnt == REG_COUNT) else $error("init length wrong");
	a_irq_raise: assert property (irq_event && !standby && !interrupt_request_n_oe
		|=> interrupt_request_n_oe) else $error("irq not raised");
	a_irq_hold: assert property (device_reset_n [*3] ##0
		(interrupt_request_n_oe && !transfer_ack_n_oe) |=> interrupt_request_n_oe)
		else $error("irq dropped early");
	a_cs_ignored: assert property (chip_select_n [*8] |-> !$rose(transfer_ack_n_oe))
		else $error("ack while unselected");
	a_write_take: assert property ($rose(transfer_ack_n_oe) && !read_not_write
		|-> reg_wr && reg_addr == addr && reg_wdata == data_in) else $error("write lost");
	a_read_answer: assert property (reg_rd |-> s_read_answer)
		else $error("read answer wrong");
	a_bus_read_only: assert property (data_oe |-> transfer_ack_n_oe && read_not_write)
		else $error("bus driven outside read");
	a_ack_release: assert property (s_released |-> !transfer_ack_n_oe && !data_oe)
		else $error("ack not released");
endmodule : hpr_host_port_asserts

bind hpr_host_port hpr_host_port_asserts #(.REG_COUNT(REG_COUNT), .REG_DEFAULT(REG_DEFAULT))
	hpr_host_port_asserts_inst (.*);

`default_nettype wire

// [hpr_host_model.sv]
/*
 * Host processor model on the asynchronous 8-bit bus, with the data wire resolution.
 * Assumes the bench calls access() from one process only.
 */
`timescale 1ns/1ps
`default_nettype none

module hpr_host_model (
	input wire logic mclk,
	input wire logic transfer_ack_n_oe,
	input wire logic transfer_ack_n_out,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	output logic chip_select_n,
	output logic data_strobe_n,
	output logic read_not_write,
	output logic [10:0] addr,
	output logic [7:0] data_in
);
	// ****************
	// Bus wires
	// ****************
	logic drv;
	logic [7:0] hd;
	logic [7:0] last;
	wire ack_n = transfer_ack_n_oe ? transfer_ack_n_out : 1'b1; // Pull-up wins when nobody sinks

	// Idle pins at time zero
	initial
	begin
		chip_select_n = 1'b1;
		data_strobe_n = 1'b1;
		read_not_write = 1'b1;
		addr = 11'h000;
		drv = 1'b0;
		hd = 8'h00;
		last = 8'h00;
	end

	// Undriven bus drifts, so a stale value never passes for data
	assign data_in = data_oe ? data_out : (drv ? hd : ~last);
	always @(posedge mclk)
		last <= data_in;

	// One access; waits for ack, then releases and waits for ack release
	task automatic access(input logic rnw, input logic [10:0] a, input logic [7:0] wd,
		input logic sel, output logic acked);
		int n;
		n = 0;
		@(posedge mclk);
		read_not_write <= rnw;
		addr <= a;
		hd <= wd;
		drv <= !rnw;
		chip_select_n <= !sel;
		@(posedge mclk);
		data_strobe_n <= 1'b0;
		do
		begin
			@(posedge mclk);
			n++;
		end while (ack_n !== 1'b0 && n < 40);
		acked = (ack_n === 1'b0);
		chip_select_n <= 1'b1;
		data_strobe_n <= 1'b1;
		drv <= 1'b0;
		while (ack_n === 1'b0 && n < 80)
		begin
			@(posedge mclk);
			n++;
		end
	endtask : access
endmodule : hpr_host_model

`default_nettype wire

// [hpr_host_port_bench.sv]
/*
 * Self-checking bench for the host port: register traffic, interrupt FIFO, device reset.
 * Assumes the checker is bound in and the host model drives the bus pins.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
	$display("unexpected %s: expected %h, seen %h", what, exp, got); end end

module hpr_host_port_bench;
	// ****************
	// Stimulus and checking
	// ****************
	localparam int REG_COUNT = 4;
	localparam int IRQ_DEPTH = 4;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic device_reset_n = 1'b1;
	logic irq_event = 1'b0;
	logic [7:0] irq_code = 8'h00;
	logic [7:0] reg_rdata = 8'h00;
	logic chip_select_n, data_strobe_n, read_not_write, data_oe, transfer_ack_n_oe;
	logic interrupt_request_n_oe, irq_dropped, standby, init_active, reg_wr, reg_rd;
	logic transfer_ack_n_out, interrupt_request_n_out;
	// Interrupt wire as the host sees it, with its pull-up
	wire irq_pin_n = interrupt_request_n_oe ? interrupt_request_n_out : 1'b1;
	logic [10:0] addr, reg_addr;
	logic [7:0] data_in, data_out, reg_wdata, exp_v;
	logic [7:0] mem [16];
	logic [7:0] shadow [16];
	logic [7:0] expq [$];
	logic ack_was = 1'b0;
	int n_fail = 0;
	int checks_done = 0;
	int drops = 0;

	hpr_host_port #(.REG_COUNT(REG_COUNT), .IRQ_DEPTH(IRQ_DEPTH)) hpr_host_port_inst (.*);
	hpr_host_model hpr_host_model_inst (.*);

	always #10 mclk = ~mclk;

	// Register file behind the port: one cycle read latency
	always @(posedge mclk)
	begin
		if (reg_wr)
			mem[reg_addr[3:0]] <= reg_wdata;
		reg_rdata <= mem[reg_addr[3:0]];
		if (irq_dropped === 1'b1)
			drops++;
	end

	// Each new read ack takes the oldest expected byte
	always @(posedge mclk)
	begin
		if (transfer_ack_n_oe === 1'b1 && !ack_was && data_oe === 1'b1)
		begin
			exp_v = (expq.size() > 0) ? expq.pop_front() : 8'hXX;
			`CHK("read_data", exp_v, data_out)
		end
		ack_was = (transfer_ack_n_oe === 1'b1);
	end

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// Waits for the init walk to start, then counts its cycles; outputs read pre-edge
	task automatic wait_idle();
		int k;
		int n;
		k = 0;
		n = 1;
		while (init_active !== 1'b1 && k < 20)
		begin
			@(posedge mclk);
			k++;
		end
		while (init_active === 1'b1 && n < 50)
		begin
			@(posedge mclk);
			if (init_active === 1'b1)
				n++;
		end
		`CHK("init_len", REG_COUNT, n)
		`CHK("init_done", 1'b0, init_active)
	endtask : wait_idle

	// Whole run is about 300 cycles; a generous multiple cuts a hang
	initial
	begin
		#(20 * 8000);
		n_fail++;
		give_verdict();
	end

	initial
	begin
		logic [10:0] a;
		logic [7:0] d;
		logic ok;
		void'($urandom(32'hEBEE));
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		wait_idle();
		for (int i = 0; i < 6; i++)
		begin
			a = 11'($urandom_range(15, 1));
			d = 8'($urandom);
			hpr_host_model_inst.access(1'b0, a, d, 1'b1, ok);
			shadow[a[3:0]] = d;
			expq.push_back(shadow[a[3:0]]);
			hpr_host_model_inst.access(1'b1, a, 8'h00, 1'b1, ok);
			`CHK("ack", 1'b1, ok)
		end
		hpr_host_model_inst.access(1'b1, 11'h001, 8'h00, 1'b0, ok);
		`CHK("ack_unselected", 1'b0, ok)
		// One entry more than the FIFO holds: the last is dropped
		for (int i = 0; i <= IRQ_DEPTH; i++)
		begin
			d = 8'($urandom);
			if (i < IRQ_DEPTH)
				expq.push_back(d);
			@(posedge mclk);
			irq_event <= 1'b1;
			irq_code <= d;
		end
		@(posedge mclk);
		irq_event <= 1'b0;
		@(posedge mclk);
		`CHK("drops", 1, drops)
		for (int i = 0; i < IRQ_DEPTH; i++)
		begin
			`CHK("irq_line", 1'b0, irq_pin_n)
			hpr_host_model_inst.access(1'b1, 11'h000, 8'h00, 1'b1, ok);
		end
		repeat (2) @(posedge mclk);
		`CHK("irq_line", 1'b1, irq_pin_n)
		expq.push_back(8'h00);
		hpr_host_model_inst.access(1'b1, 11'h000, 8'h00, 1'b1, ok);
		hpr_host_model_inst.access(1'b0, 11'h003, 8'hA5, 1'b1, ok);
		@(posedge mclk);
		irq_event <= 1'b1;
		irq_code <= 8'h5A;
		@(posedge mclk);
		irq_event <= 1'b0;
		device_reset_n <= 1'b0;
		repeat (6) @(posedge mclk);
		`CHK("standby", 1'b1, standby)
		`CHK("irq_flushed", 1'b1, irq_pin_n)
		device_reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		`CHK("init_restart", 1'b1, init_active)
		wait_idle();
		expq.push_back(8'h00);
		hpr_host_model_inst.access(1'b1, 11'h003, 8'h00, 1'b1, ok);
		repeat (4) @(posedge mclk);
		`CHK("reads_left", 0, expq.size())
		give_verdict();
	end
endmodule : hpr_host_port_bench

`default_nettype wire
